/* core/tpm_pkg.sv */
package tpm_pkg;

	// register byte offsets
	localparam logic [7:0] TPM_OFF_COUNT = 8'h00; // count / reload register
	localparam logic [7:0] TPM_OFF_MODE  = 8'h04; // channel mode register
	localparam logic [7:0] TPM_OFF_START = 8'h08; // count start flag
	localparam logic [7:0] TPM_OFF_STAT  = 8'h0c; // status: overflow, events, pin

	// mode register field positions
	localparam int TPM_MODE_OP_LO   = 0; // two bits: operating mode
	localparam int TPM_MODE_SRC_LO  = 2; // two bits: count source
	localparam int TPM_MODE_EDGE    = 4; // measure: 0 falling, 1 rising
	localparam int TPM_MODE_BOTH    = 5; // measure: both edges (width)
	localparam int TPM_MODE_PWM8    = 6; // pwm: 8-bit with prescaler
	localparam int TPM_MODE_TRIG_OV = 7; // pwm: wait for overflow trigger
	localparam logic [7:0] TPM_MODE_RST = 8'h00;

	// status bit positions
	localparam int TPM_ST_OVF  = 0;
	localparam int TPM_ST_EDGE = 1;
	localparam int TPM_ST_PWM  = 2;
	localparam int TPM_ST_PIN  = 3;

	// operating modes
	localparam logic [1:0] TPM_OP_IDLE    = 2'h0;
	localparam logic [1:0] TPM_OP_MEASURE = 2'h1;
	localparam logic [1:0] TPM_OP_PWM     = 2'h2;

	// prescaler ratios for the four count sources
	localparam logic [4:0] TPM_DIV1     = 5'h00;
	localparam logic [4:0] TPM_DIV8     = 5'h07;
	localparam logic [4:0] TPM_DIV32    = 5'h1f;
	localparam int         TPM_SUB_DIV  = 32;
	localparam logic [15:0] TPM_CNT_RST = 16'h0000;

	typedef enum logic [1:0] {
		TPM_PWM_STOP,
		TPM_PWM_WAIT,
		TPM_PWM_RUN
	} tpm_pwm_state_t;

endpackage : tpm_pkg

/* core/tpm_timer.sv */
// Behaviour
// - measure mode counts up on count clock
// - effective edge captures count, restarts from zero
// - start flag runs and halts measurement count
// - edge interrupt, except first after start
// - overflow raises interrupt and overflow flag
// - overflow clears on mode write while started
// - count read returns captured reload value
// - measure mode ignores count register writes
// - pwm down-counts, 16-bit or 8-bit prescaled
// - pwm reloads at output rising edge
// - triggers ignored while pwm counts
// - 16-bit high n, period 65535 clocks
// - 8-bit high n(m+1), period 255(m+1)
// - pwm starts on flag, optional overflow trigger
// - 8-bit event at fall or count 01h
// - 16-bit event at fall or count 0001h
// - zero width holds low, loads full-scale count
// - pwm drives pin, count read undefined
// - pwm write loads reload only, used at first step or next reload
`timescale 1ns/1ps
module tpm_timer
	import tpm_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        channel_io_pin_in,
	input  wire logic        subclock_div32,
	input  wire logic        overflow_trigger,
	output logic             channel_io_pin_out,
	output logic             channel_io_pin_oe_n,
	output logic             timer_irq_pulse
);

	logic [7:0]  mode_q;
	logic        start_q;
	logic        ovf_q;
	logic        edge_ev_q;
	logic        pwm_ev_q;
	logic [15:0] reload_q;
	logic [15:0] cnt_q;
	logic [7:0]  pre_q;
	logic        first_q;
	logic        pin_s1_q;
	logic        pin_s2_q;
	logic        pin_prev_q;
	logic        sub_s1_q;
	logic        sub_s2_q;
	logic        sub_prev_q;
	logic [4:0]  div_q;
	logic        tick;
	logic        wr_q;
	logic [7:0]  addr_q;
	logic        pwm_hi_q;
	logic [15:0] pwm_n_q;
	logic [7:0]  pwm_m_q;
	tpm_pwm_state_t pwm_st_q;

	logic [1:0]  op;
	logic        eff_edge;
	logic        rd_en;
	logic        wr_en;
	logic        cnt_wr;
	logic        mode_wr;
	logic        start_wr;
	logic [15:0] pwm_top;
	logic        cnt_end;
	logic        pwm_step;
	logic        pwm_fall;
	logic        pwm_at_one;
	logic        pwm_event;
	logic        meas_edge;
	logic        meas_ovf;

	// high width n taken from the count word
	function automatic logic [15:0] pwm_width(input logic [15:0] r, input logic b8);
		if (b8)
			pwm_width = {8'h00, r[15:8]};
		else
			pwm_width = r;
	endfunction : pwm_width

	// full or zero width move the event to count one
	function automatic logic edge_case(input logic [15:0] n, input logic b8);
		if (b8)
			edge_case = (n[7:0] == 8'h00) || (n[7:0] == 8'hff);
		else
			edge_case = (n == 16'h0000) || (n == 16'hffff);
	endfunction : edge_case

	assign op    = mode_q[TPM_MODE_OP_LO +: 2];
	assign rd_en = hsel && hready && htrans[1] && !hwrite;
	assign wr_en = hsel && hready && htrans[1] && hwrite;
	assign cnt_wr   = wr_q && (addr_q == TPM_OFF_COUNT);
	assign mode_wr  = wr_q && (addr_q == TPM_OFF_MODE);
	assign start_wr = wr_q && (addr_q == TPM_OFF_START);

	// write address phase captured for data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q   <= 1'b0;
			addr_q <= 8'h00;
		end else if (hready) begin
			wr_q   <= wr_en;
			addr_q <= {haddr[7:2], 2'b00};
		end
	end

	// zero wait state, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// read data registered in address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case ({haddr[7:2], 2'b00})
				// pwm read is live count, undefined
				TPM_OFF_COUNT: hrdata <= {16'h0000, (op == TPM_OP_PWM) ? cnt_q : reload_q};
				TPM_OFF_MODE:  hrdata <= {24'h000000, mode_q};
				TPM_OFF_START: hrdata <= {31'h0, start_q};
				TPM_OFF_STAT:  hrdata <= {28'h0000000, channel_io_pin_out, pwm_ev_q,
					edge_ev_q, ovf_q};
				default:       hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// two-flop sync of pin and sub clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_q   <= 1'b0;
			pin_s2_q   <= 1'b0;
			pin_prev_q <= 1'b0;
			sub_s1_q   <= 1'b0;
			sub_s2_q   <= 1'b0;
			sub_prev_q <= 1'b0;
		end else begin
			pin_s1_q   <= channel_io_pin_in;
			pin_s2_q   <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
			sub_s1_q   <= subclock_div32;
			sub_s2_q   <= sub_s1_q;
			sub_prev_q <= sub_s2_q;
		end
	end

	always_comb begin
		unique case (mode_q[TPM_MODE_SRC_LO +: 2])
			2'd0: tick = 1'b1;
			2'd1: tick = (div_q[2:0] == TPM_DIV8[2:0]);
			2'd2: tick = (div_q == TPM_DIV32);
			default: tick = sub_s2_q && !sub_prev_q;
		endcase
	end

	// free-running main clock prescaler
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_q <= TPM_DIV1;
		else
			div_q <= div_q + 5'd1;
	end

	// effective edge: chosen polarity or both
	assign eff_edge = mode_q[TPM_MODE_BOTH] ? (pin_s2_q != pin_prev_q) :
		mode_q[TPM_MODE_EDGE] ? (pin_s2_q && !pin_prev_q) : (!pin_s2_q && pin_prev_q);

	// measurement events while started
	assign meas_edge = (op == TPM_OP_MEASURE) && start_q && eff_edge;
	// count about to wrap past ffff
	assign meas_ovf  = (op == TPM_OP_MEASURE) && start_q && tick && !eff_edge &&
		(cnt_q == 16'hffff);

	// mode and start flag registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q  <= TPM_MODE_RST;
			start_q <= 1'b0;
		end else begin
			if (mode_wr)
				mode_q <= hwdata[7:0];
			if (start_wr)
				start_q <= hwdata[0];
		end
	end

	// period length in steps: 255 or 65535
	assign pwm_top  = mode_q[TPM_MODE_PWM8] ? 16'h00ff : 16'hffff;
	assign cnt_end  = mode_q[TPM_MODE_PWM8] ? (cnt_q[7:0] == 8'h01) : (cnt_q == 16'h0001);
	// one modulator step: count clock, then m+1 prescale
	assign pwm_step = (pwm_st_q == TPM_PWM_RUN) && tick &&
		(!mode_q[TPM_MODE_PWM8] || pre_q == 8'h00);
	// output fall or count reaching one
	assign pwm_fall   = pwm_step && !cnt_end && pwm_hi_q &&
		(cnt_q - 16'd1 == pwm_top - pwm_n_q);
	assign pwm_at_one = pwm_step &&
		(mode_q[TPM_MODE_PWM8] ? (cnt_q[7:0] == 8'h02) : (cnt_q == 16'h0002));
	assign pwm_event  = edge_case(pwm_n_q, mode_q[TPM_MODE_PWM8]) ? pwm_at_one : pwm_fall;

	// pwm sequencing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_st_q <= TPM_PWM_STOP;
		end else if (op != TPM_OP_PWM || !start_q) begin
			pwm_st_q <= TPM_PWM_STOP;
		end else begin
			unique case (pwm_st_q)
				TPM_PWM_STOP: pwm_st_q <= mode_q[TPM_MODE_TRIG_OV] ? TPM_PWM_WAIT : TPM_PWM_RUN;
				TPM_PWM_WAIT: if (overflow_trigger) pwm_st_q <= TPM_PWM_RUN;
				TPM_PWM_RUN:  pwm_st_q <= TPM_PWM_RUN;
			endcase
		end
	end

	// counter, prescaler and reload
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q    <= TPM_CNT_RST;
			reload_q <= TPM_CNT_RST;
			pre_q    <= 8'h00;
			pwm_hi_q <= 1'b0;
			pwm_n_q  <= TPM_CNT_RST;
			pwm_m_q  <= 8'h00;
			first_q  <= 1'b1;
		end else if (op == TPM_OP_MEASURE) begin
			if (!start_q) begin
				first_q <= 1'b1;
			end else if (eff_edge) begin
				reload_q <= cnt_q;
				cnt_q    <= TPM_CNT_RST;
				first_q  <= 1'b0;
			end else if (tick) begin
				cnt_q <= cnt_q + 16'd1;
			end
		end else if (op == TPM_OP_PWM) begin
			// running write waits for the next reload
			if (cnt_wr)
				reload_q <= hwdata[15:0];
			if (pwm_st_q != TPM_PWM_RUN) begin
				// stopped: first step reloads at once
				cnt_q    <= 16'h0001;
				pre_q    <= 8'h00;
				pwm_hi_q <= 1'b0;
			end else if (pwm_step && cnt_end) begin
				// full-scale load, zero width stays low
				cnt_q    <= pwm_top;
				pwm_n_q  <= pwm_width(reload_q, mode_q[TPM_MODE_PWM8]);
				pwm_m_q  <= reload_q[7:0];
				pre_q    <= reload_q[7:0];
				pwm_hi_q <= (pwm_width(reload_q, mode_q[TPM_MODE_PWM8]) != 16'h0000);
			end else if (pwm_step) begin
				// down count, high for n steps
				cnt_q <= cnt_q - 16'd1;
				pre_q <= pwm_m_q;
				if (pwm_fall)
					pwm_hi_q <= 1'b0;
			end else if (tick) begin
				pre_q <= pre_q - 8'd1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ovf_q <= 1'b0;
		else if (meas_ovf)
			ovf_q <= 1'b1;
		else if (mode_wr && start_q)
			ovf_q <= 1'b0;
	end

	// interrupt pulse and event status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_irq_pulse <= 1'b0;
			edge_ev_q       <= 1'b0;
			pwm_ev_q        <= 1'b0;
		end else begin
			edge_ev_q <= meas_edge && !first_q;
			pwm_ev_q  <= pwm_event;
			timer_irq_pulse <= (meas_edge && !first_q) || meas_ovf || pwm_event;
		end
	end

	// pin drives out only in pwm
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel_io_pin_out  <= 1'b0;
			channel_io_pin_oe_n <= 1'b1;
		end else begin
			channel_io_pin_out  <= pwm_hi_q;
			channel_io_pin_oe_n <= (op != TPM_OP_PWM);
		end
	end

endmodule : tpm_timer

/* verification/tpm_timer_assertions.sv */
`timescale 1ns/1ps
module tpm_assert_chk
	import tpm_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        channel_io_pin_out,
	input wire logic        channel_io_pin_oe_n,
	input wire logic        timer_irq_pulse
);
	logic        wr_q, st_q, seen_q;
	logic [7:0]  a_q, mode_q;
	logic [15:0] new_q, cnt_q;
	logic [16:0] hi_q, per_q;
	wire         pin   = channel_io_pin_out;
	wire         pwm_m = mode_q[1:0] == TPM_OP_PWM;
	wire         run   = pwm_m && st_q;
	wire         div1  = run && mode_q[3:2] == 2'h0;
	wire         p8    = mode_q[TPM_MODE_PWM8];
	wire [15:0]  nval  = p8 ? {8'h00, cnt_q[15:8]} : cnt_q;
	wire [16:0]  mul   = {9'h000, cnt_q[7:0]} + 17'h00001;
	wire [16:0]  e_hi  = p8 ? {9'h000, cnt_q[15:8]} * mul : {1'h0, cnt_q};
	wire [16:0]  e_per = p8 ? 17'h000ff * mul : 17'h0ffff;
	wire         mid_n = nval != 16'h0000 && nval != (p8 ? 16'h00ff : 16'hffff);
	// shadow of register writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q   <= 1'b0;
			a_q    <= 8'h00;
			mode_q <= TPM_MODE_RST;
			st_q   <= 1'b0;
			new_q  <= 16'h0000;
		end else begin
			wr_q <= hsel && hready && htrans[1] && hwrite;
			a_q  <= haddr[7:0];
			if (wr_q && a_q == TPM_OFF_MODE) mode_q <= hwdata[7:0];
			if (wr_q && a_q == TPM_OFF_START) st_q <= hwdata[0];
			if (wr_q && a_q == TPM_OFF_COUNT) new_q <= hwdata[15:0];
		end
	end
	// active setting, taken at reload; high and period lengths
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q  <= 16'h0000;
			hi_q   <= 17'h00000;
			per_q  <= 17'h00000;
			seen_q <= 1'b0;
		end else begin
			if (!run)
				cnt_q <= new_q;
			else if ($rose(pin))
				cnt_q <= $past(new_q, 2);
			hi_q   <= pin ? hi_q + 17'h00001 : 17'h00000;
			per_q  <= $rose(pin) ? 17'h00001 : per_q + 17'h00001;
			seen_q <= run && (seen_q || $rose(pin));
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence fall_mid;
		$fell(pin) && run && mid_n;
	endsequence
	sequence irq_before;
		$past(timer_irq_pulse);
	endsequence
	AST_PWM_HIGH: assert property ($fell(pin) && div1 && seen_q |-> hi_q == e_hi)
		else $error("pwm high time wrong");
	AST_PWM_PERIOD: assert property ($rose(pin) && div1 && seen_q |-> per_q == e_per)
		else $error("pwm period wrong");
	AST_PWM_FALL_IRQ: assert property (fall_mid |-> irq_before)
		else $error("no request at pwm fall");
	AST_ZERO_LOW: assert property (run && $past(run, 4) && nval == 16'h0000 |-> !pin)
		else $error("zero width pwm high");
	AST_OE_PWM: assert property (pwm_m && $past(pwm_m, 2) |-> !channel_io_pin_oe_n)
		else $error("pin not driven in pwm");
	AST_OE_OFF: assert property (!pwm_m && !$past(pwm_m, 2) |-> channel_io_pin_oe_n)
		else $error("pin driven outside pwm");
	AST_STOP_QUIET: assert property ((!st_q) [*8] |-> !timer_irq_pulse)
		else $error("request while stopped");
	AST_IRQ_PULSE: assert property (timer_irq_pulse |=> !timer_irq_pulse)
		else $error("request longer than a cycle");
endmodule : tpm_assert_chk

bind tpm_timer tpm_assert_chk u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.channel_io_pin_out(channel_io_pin_out), .channel_io_pin_oe_n(channel_io_pin_oe_n),
	.timer_irq_pulse(timer_irq_pulse)
);

/* verification/tpm_pulse_src.sv */
`timescale 1ns/1ps
module tpm_pulse_src (
	input  wire logic        hclk,
	input  wire logic        run,
	input  wire logic [15:0] per,
	output logic             pin
);
	logic [15:0] ph_q = 16'h0000;
	initial pin = 1'b0;
	// square wave, high half first, low when idle
	always @(posedge hclk) begin
		ph_q <= (!run || ph_q >= per - 16'h0001) ? 16'h0000 : ph_q + 16'h0001;
		pin  <= run && ph_q < (per >> 1);
	end
endmodule : tpm_pulse_src

/* verification/timer_pulse_measure_pwm_test.sv */
`timescale 1ns/1ps
module timer_pulse_measure_pwm_test
	import tpm_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, trig_en, src_run;
	logic        ovf_trig = 1'b0;
	logic        pin_d = 1'b0;
	logic [31:0] haddr, hwdata, rd, c1;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [4:0]  sub_q = 5'h00;
	logic [15:0] src_per;
	wire  [31:0] hrdata;
	wire         hready, hresp, pin_in, pin_out, oe_n, irq;
	int          mismatches, checks_done, seed, i, n, m, p, e0, r0;
	int          irqs = 0;
	int          rises = 0;
	int          his = 0;

	tpm_timer uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .channel_io_pin_in(pin_in),
		.subclock_div32(sub_q[4]), .overflow_trigger(ovf_trig),
		.channel_io_pin_out(pin_out), .channel_io_pin_oe_n(oe_n), .timer_irq_pulse(irq)
	);
	tpm_pulse_src u_src (.hclk(hclk), .run(src_run), .per(src_per), .pin(pin_in));

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	// event counters, sub clock and random triggers
	always @(posedge hclk) begin
		pin_d    <= pin_in;
		irqs     <= irqs + int'(irq === 1'b1);
		rises    <= rises + int'(pin_in && !pin_d);
		his      <= his + int'(pin_out === 1'b1);
		sub_q    <= sub_q + 5'h01;
		ovf_trig <= trig_en && ($random(seed) % 40 == 0);
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one single transfer; read data kept in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic window(input int per, input int hi);
		int h0, q0;
		repeat (2 * per) @(posedge hclk);
		h0 = his;
		q0 = irqs;
		repeat (4 * per) @(posedge hclk);
		chk("pwm requests", irqs - q0, 4);
		chk("pwm high time", his - h0, 4 * hi);
	endtask : window
	task automatic wrap_up;
		if (mismatches == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (99000) @(posedge hclk);
		mismatches++;
		wrap_up();
	end
	initial begin
		seed = 29;
		{hresetn, hsel, hwrite, trig_en, src_run} = 5'h00;
		{haddr, hwdata} = 64'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		src_per = 16'h0010;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		// idle after reset, unmapped offset reads zero
		for (i = 0; i <= 16; i += 4) begin
			bus(1'b0, i[7:0], 32'h0);
			chk("reset read", rd, 32'h0);
		end
		// period measurement on every count source
		for (i = 0; i < 4; i++) begin
			p = (i == 0) ? 1 : (i == 1) ? 8 : 32;
			n = p * (16 + {$random(seed)} % 16);
			m = n + p * (1 + {$random(seed)} % 15);
			bus(1'b1, TPM_OFF_MODE, 32'h11 | (i << 2));
			bus(1'b1, TPM_OFF_START, 32'h1);
			e0 = irqs;
			r0 = rises;
			src_per <= 16'(n);
			src_run <= 1'b1;
			repeat (3 * n) @(posedge hclk);
			bus(1'b0, TPM_OFF_COUNT, 32'h0);
			c1 = rd;
			src_per <= 16'(m);
			repeat (3 * m + 8) @(posedge hclk);
			bus(1'b0, TPM_OFF_COUNT, 32'h0);
			chk("period step", rd - c1, (m - n) / p);
			c1 = rd;
			bus(1'b1, TPM_OFF_COUNT, $random(seed));
			bus(1'b0, TPM_OFF_COUNT, 32'h0);
			chk("count after write", rd, c1);
			src_run <= 1'b0;
			repeat (10) @(posedge hclk);
			chk("edge requests", irqs - e0, rises - r0 - 1);
			bus(1'b1, TPM_OFF_START, 32'h0);
		end
		// overflow with no pulse applied
		bus(1'b1, TPM_OFF_MODE, 32'h11);
		bus(1'b1, TPM_OFF_START, 32'h1);
		e0 = irqs;
		repeat (65560) @(posedge hclk);
		chk("overflow request", irqs - e0, 1);
		bus(1'b0, TPM_OFF_STAT, 32'h0);
		chk("overflow flag", rd[0], 1'b1);
		bus(1'b1, TPM_OFF_START, 32'h0);
		bus(1'b1, TPM_OFF_MODE, 32'h11);
		bus(1'b0, TPM_OFF_STAT, 32'h0);
		chk("flag kept", rd[0], 1'b1);
		bus(1'b1, TPM_OFF_START, 32'h1);
		bus(1'b1, TPM_OFF_MODE, 32'h11);
		bus(1'b0, TPM_OFF_STAT, 32'h0);
		chk("flag cleared", rd[0], 1'b0);
		bus(1'b1, TPM_OFF_START, 32'h0);
		// pwm: 8-bit with trigger, zero, full, then 16-bit
		for (i = 0; i < 4; i++) begin
			m = {$random(seed)} % 2;
			p = 255 * (m + 1);
			n = (i == 1) ? 0 : (i == 2) ? 255 : 1 + {$random(seed)} % 254;
			bus(1'b1, TPM_OFF_MODE, (i == 0) ? 32'hc2 : (i == 3) ? 32'h02 : 32'h42);
			bus(1'b1, TPM_OFF_COUNT, (i == 3) ? n : n * 256 + m);
			bus(1'b1, TPM_OFF_START, 32'h1);
			chk("pin driven", oe_n, 1'b0);
			e0 = irqs;
			r0 = his;
			if (i == 3) begin
				repeat (n + 20) @(posedge hclk);
				chk("16-bit request", irqs - e0, 1);
				chk("16-bit high", his - r0, n);
			end else begin
				repeat (40) @(posedge hclk);
				if (i == 0) chk("trigger wait", his - r0, 0);
				trig_en <= 1'b1;
				window(p, n * (m + 1));
				if (i == 0) begin
					bus(1'b1, TPM_OFF_COUNT, (255 - n) * 256 + m);
					window(p, (255 - n) * (m + 1));
				end
			end
			bus(1'b1, TPM_OFF_START, 32'h0);
		end
		wrap_up();
	end
endmodule : timer_pulse_measure_pwm_test
